// File: rtl/csfc_pkg.sv
// Constants and types for the sink B drive level and flash control block
package csfc_pkg;
   // Register offsets
   localparam logic [7:0]  CSFC_ADDR_LEVEL    = 8'hae;
   localparam logic [7:0]  CSFC_ADDR_FLASH    = 8'haf;
   // Drive level register fields
   localparam int          CSFC_ENA_BIT       = 15;
   localparam int          CSFC_CODE_LSB      = 0;
   localparam int          CSFC_CODE_W        = 6;
   // Flash control register fields
   localparam int          CSFC_FMODE_BIT     = 15;
   localparam int          CSFC_TSRC_BIT      = 14;
   localparam int          CSFC_DRIVE_BIT     = 13;
   localparam int          CSFC_RATE_BIT      = 12;
   localparam int          CSFC_DUR_LSB       = 8;
   localparam int          CSFC_OFFR_LSB      = 4;
   localparam int          CSFC_ONR_LSB       = 0;
   // Reset values
   localparam logic [15:0] CSFC_LEVEL_RST     = 16'h0000;
   localparam logic [15:0] CSFC_FLASH_RST     = 16'h0000;
   // Clock
   localparam longint      CSFC_CLK_HZ        = 20_000_000;
   localparam longint      CSFC_CLK_NS        = 1_000_000_000 / CSFC_CLK_HZ;
   // Times in ns
   localparam longint      CSFC_DUR0_NS       = 32_000_000;
   localparam longint      CSFC_DUR1_NS       = 64_000_000;
   localparam longint      CSFC_DUR2_NS       = 96_000_000;
   localparam longint      CSFC_DUR3_NS       = 1_024_000_000;
   localparam longint      CSFC_REPEAT_NS     = 64'hee6b_2800;
   localparam longint      CSFC_LRAMP1_NS     = 250_000_000;
   localparam longint      CSFC_LRAMP2_NS     = 500_000_000;
   localparam longint      CSFC_LRAMP3_NS     = 1_000_000_000;
   localparam longint      CSFC_FRAMP1_NS     = 1_950_000;
   localparam longint      CSFC_FRAMP2_NS     = 3_910_000;
   localparam longint      CSFC_FRAMP3_NS     = 7_800_000;
   // Cycle counts, rounded down
   localparam int unsigned CSFC_DUR0_CYC      = int'(CSFC_DUR0_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_DUR1_CYC      = int'(CSFC_DUR1_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_DUR2_CYC      = int'(CSFC_DUR2_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_DUR3_CYC      = int'(CSFC_DUR3_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_REPEAT_CYC    = int'(CSFC_REPEAT_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_LRAMP1_CYC    = int'(CSFC_LRAMP1_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_LRAMP2_CYC    = int'(CSFC_LRAMP2_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_LRAMP3_CYC    = int'(CSFC_LRAMP3_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_FRAMP1_CYC    = int'(CSFC_FRAMP1_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_FRAMP2_CYC    = int'(CSFC_FRAMP2_NS / CSFC_CLK_NS);
   localparam int unsigned CSFC_FRAMP3_CYC    = int'(CSFC_FRAMP3_NS / CSFC_CLK_NS);
   // A ramp walks the level code one step at a time
   localparam int unsigned CSFC_RAMP_STEPS    = 64;
   localparam int          CSFC_TW            = 27;
   // Flash sequencer states
   typedef enum logic [1:0] {
      CSFC_IDLE  = 2'b00,
      CSFC_FLASH = 2'b01,
      CSFC_WAIT  = 2'b10
   } csfc_flash_t;
endpackage

// File: rtl/csfc_ramp.sv
// Level code ramp between zero and the target code
module csfc_ramp import csfc_pkg::*; (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Control
   input  wire logic                   on,
   input  wire logic [CSFC_CODE_W-1:0] target,
   input  wire logic [CSFC_TW-1:0]     up_step,
   input  wire logic [CSFC_TW-1:0]     dn_step,
   // Result
   output logic      [CSFC_CODE_W-1:0] level
);
   typedef struct packed {
      logic [CSFC_CODE_W-1:0] level;
      logic [CSFC_TW-1:0]     cnt;
   } csfc_ramp_t;

   csfc_ramp_t             s_r;
   csfc_ramp_t             s_nxt;
   logic [CSFC_CODE_W-1:0] goal;

   always_comb begin
      s_nxt = s_r;
      goal  = on ? target : '0;
      if (s_r.level == goal) begin
         s_nxt.cnt = '0;
      end else if (s_r.level > goal) begin
         // Falling: instant while on or with no off ramp
         if (on || dn_step == '0) begin
            s_nxt.level = goal;
            s_nxt.cnt   = '0;
         end else if (s_r.cnt >= dn_step - 1'b1) begin
            s_nxt.level = s_r.level - 1'b1;
            s_nxt.cnt   = '0;
         end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end else begin
         if (up_step == '0) begin
            s_nxt.level = goal;
            s_nxt.cnt   = '0;
         end else if (s_r.cnt >= up_step - 1'b1) begin
            s_nxt.level = s_r.level + 1'b1;
            s_nxt.cnt   = '0;
         end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.level;

   a_off_instant : assert property (@(posedge clk) disable iff (!rst_n)
      !on && dn_step == '0 |=> level == '0)
      else $error("off without ramp did not drop the level at once");
endmodule

// File: rtl/csfc_top.sv
// Sink B drive level registers and flash sequencer
// Operation
// - Hold six-bit monotonic drive level code
// - Control bit 15 picks LED or flash
// - Bit 14 zero: drive bit triggers flash
// - Bit 14 one: trigger pin starts flash
// - Trigger source ignored in LED mode
// - LED mode: drive bit gates sink
// - Flash mode, register source: drive bit rising starts a flash
// - Register source: drive bit self-clears when flash ends
// - Pin source: drive writes start nothing
// - Bit 12 repeats flash every 4 s
// - Bits 9:8 set flash length
// - Off ramp 00 switches off instantly
// - All fields reset to zero
// - Ramp times differ for LED, flash
// - Bits 1:0 select the on ramp
// - Master enable gates the sink request, not the off ramp
module csfc_top import csfc_pkg::*; #(
   parameter int unsigned DUR0_CYC   = CSFC_DUR0_CYC,
   parameter int unsigned DUR1_CYC   = CSFC_DUR1_CYC,
   parameter int unsigned DUR2_CYC   = CSFC_DUR2_CYC,
   parameter int unsigned DUR3_CYC   = CSFC_DUR3_CYC,
   parameter int unsigned REPEAT_CYC = CSFC_REPEAT_CYC,
   parameter int unsigned LRAMP1_CYC = CSFC_LRAMP1_CYC,
   parameter int unsigned LRAMP2_CYC = CSFC_LRAMP2_CYC,
   parameter int unsigned LRAMP3_CYC = CSFC_LRAMP3_CYC,
   parameter int unsigned FRAMP1_CYC = CSFC_FRAMP1_CYC,
   parameter int unsigned FRAMP2_CYC = CSFC_FRAMP2_CYC,
   parameter int unsigned FRAMP3_CYC = CSFC_FRAMP3_CYC
) (
   // Clock and reset
   input  wire logic                   CLOCK,
   input  wire logic                   RESET_N,
   // Register port
   input  wire logic [7:0]             ADDR,
   input  wire logic [15:0]            WDATA,
   input  wire logic                   WR,
   input  wire logic                   RD,
   output logic      [15:0]            RDATA,
   // Flash trigger pin
   input  wire logic                   FLASH_TRIGGER,
   // Sink drive
   output logic                        SINK_B_OUTPUT,
   output logic      [CSFC_CODE_W-1:0] SINK_B_LEVEL,
   output logic                        SINK_B_FLASH_ACTIVE
);
   typedef struct packed {
      logic                   master_enable;
      logic [CSFC_CODE_W-1:0] level_code;
      logic                   function_select;
      logic                   trigger_source;
      logic                   drive_bit;
      logic                   repeat_select;
      logic [1:0]             pulse_length;
      logic [1:0]             off_ramp;
      logic [1:0]             on_ramp;
      logic                   drive_q;
      logic                   pin_s1;
      logic                   pin_s2;
      logic                   pin_q;
      csfc_flash_t            state;
      logic [CSFC_TW-1:0]     timer;
      logic [15:0]            rdata;
   } csfc_state_t;

   csfc_state_t            s_r;
   csfc_state_t            s_nxt;
   logic                   pin_rise;
   logic                   drive_rise;
   logic                   trig;
   logic                   on_req;
   logic                   wr_level;
   logic                   wr_flash;
   logic [CSFC_TW-1:0]     dur_last;
   logic [CSFC_TW-1:0]     up_step;
   logic [CSFC_TW-1:0]     dn_step;
   logic [CSFC_CODE_W-1:0] ramp_level;

   // Flash length in cycles for a pulse length code
   function automatic logic [CSFC_TW-1:0] dur_cyc(input logic [1:0] code);
      logic [CSFC_TW-1:0] r;
      r = '0;
      case (code)
         2'h0: r = CSFC_TW'(DUR0_CYC);
         2'h1: r = CSFC_TW'(DUR1_CYC);
         2'h2: r = CSFC_TW'(DUR2_CYC);
         default: r = CSFC_TW'(DUR3_CYC);
      endcase
      return r;
   endfunction

   // Cycles per level step of a ramp; zero means no ramp
   function automatic logic [CSFC_TW-1:0] ramp_step(input logic flash, input logic [1:0] code);
      int unsigned t;
      t = 0;
      case (code)
         2'h1: t = flash ? FRAMP1_CYC : LRAMP1_CYC;
         2'h2: t = flash ? FRAMP2_CYC : LRAMP2_CYC;
         2'h3: t = flash ? FRAMP3_CYC : LRAMP3_CYC;
         default: t = 0;
      endcase
      return CSFC_TW'(t / CSFC_RAMP_STEPS);
   endfunction

   // Pin edge seen only from the second synchroniser stage
   assign pin_rise   = s_r.pin_s2 && !s_r.pin_q;
   assign drive_rise = s_r.drive_bit && !s_r.drive_q;
   assign dur_last   = dur_cyc(s_r.pulse_length) - 1'b1;
   assign wr_level   = WR && ADDR == CSFC_ADDR_LEVEL;
   assign wr_flash   = WR && ADDR == CSFC_ADDR_FLASH;

   // Trigger source chosen only in flash mode, gated by enable
   always_comb begin
      trig = 1'b0;
      if (s_r.master_enable && s_r.function_select) begin
         if (s_r.trigger_source) begin
            trig = pin_rise;
         end else begin
            trig = drive_rise;
         end
      end
   end

   always_comb begin
      s_nxt        = s_r;
      s_nxt.pin_s1 = FLASH_TRIGGER;
      s_nxt.pin_s2 = s_r.pin_s1;
      s_nxt.pin_q  = s_r.pin_s2;
      s_nxt.rdata  = '0;

      // Flash sequencer
      case (s_r.state)
         CSFC_IDLE: begin
            if (trig) begin
               s_nxt.state = CSFC_FLASH;
               s_nxt.timer = '0;
            end
         end
         CSFC_FLASH: begin
            // New triggers are ignored until the pulse ends
            if (s_r.timer >= dur_last) begin
               if (!s_r.trigger_source) begin
                  s_nxt.drive_bit = 1'b0;
               end
               if (s_r.repeat_select) begin
                  s_nxt.state = CSFC_WAIT;
                  s_nxt.timer = s_r.timer + 1'b1;
               end else begin
                  s_nxt.state = CSFC_IDLE;
                  s_nxt.timer = '0;
               end
            end else begin
               s_nxt.timer = s_r.timer + 1'b1;
            end
         end
         CSFC_WAIT: begin
            // Repeat period counts from the start of the last flash
            if (!s_r.repeat_select) begin
               s_nxt.state = CSFC_IDLE;
               s_nxt.timer = '0;
            end else if (s_r.timer >= CSFC_TW'(REPEAT_CYC - 1)) begin
               s_nxt.state = CSFC_FLASH;
               s_nxt.timer = '0;
            end else begin
               s_nxt.timer = s_r.timer + 1'b1;
            end
         end
         default: begin
            s_nxt.state = CSFC_IDLE;
            s_nxt.timer = '0;
         end
      endcase

      // Leaving flash mode or disabling aborts any flash
      if (!s_r.master_enable || !s_r.function_select) begin
         s_nxt.state = CSFC_IDLE;
         s_nxt.timer = '0;
      end

      // Edge reference taken before software writes, so a set that
      // meets the self-clear still gives a fresh edge
      s_nxt.drive_q = s_nxt.drive_bit;

      // Register writes win over the hardware clear
      if (wr_level) begin
         s_nxt.master_enable = WDATA[CSFC_ENA_BIT];
         s_nxt.level_code    = WDATA[CSFC_CODE_LSB +: CSFC_CODE_W];
      end
      if (wr_flash) begin
         s_nxt.function_select = WDATA[CSFC_FMODE_BIT];
         s_nxt.trigger_source  = WDATA[CSFC_TSRC_BIT];
         s_nxt.drive_bit       = WDATA[CSFC_DRIVE_BIT];
         s_nxt.repeat_select   = WDATA[CSFC_RATE_BIT];
         s_nxt.pulse_length    = WDATA[CSFC_DUR_LSB +: 2];
         s_nxt.off_ramp        = WDATA[CSFC_OFFR_LSB +: 2];
         s_nxt.on_ramp         = WDATA[CSFC_ONR_LSB +: 2];
      end

      // Read data stands only in the cycle after the strobe
      if (RD) begin
         if (ADDR == CSFC_ADDR_LEVEL) begin
            s_nxt.rdata[CSFC_ENA_BIT]                  = s_r.master_enable;
            s_nxt.rdata[CSFC_CODE_LSB +: CSFC_CODE_W] = s_r.level_code;
         end else if (ADDR == CSFC_ADDR_FLASH) begin
            s_nxt.rdata[CSFC_FMODE_BIT]      = s_r.function_select;
            s_nxt.rdata[CSFC_TSRC_BIT]       = s_r.trigger_source;
            s_nxt.rdata[CSFC_DRIVE_BIT]      = s_r.drive_bit;
            s_nxt.rdata[CSFC_RATE_BIT]       = s_r.repeat_select;
            s_nxt.rdata[CSFC_DUR_LSB +: 2]  = s_r.pulse_length;
            s_nxt.rdata[CSFC_OFFR_LSB +: 2] = s_r.off_ramp;
            s_nxt.rdata[CSFC_ONR_LSB +: 2]  = s_r.on_ramp;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // LED mode follows the drive bit, flash mode the sequencer
   always_comb begin
      on_req = 1'b0;
      if (s_r.master_enable) begin
         if (s_r.function_select) begin
            on_req = s_r.state == CSFC_FLASH;
         end else begin
            on_req = s_r.drive_bit;
         end
      end
   end

   assign up_step = ramp_step(s_r.function_select, s_r.on_ramp);
   assign dn_step = ramp_step(s_r.function_select, s_r.off_ramp);

   csfc_ramp u_ramp (
      .clk    (CLOCK),
      .rst_n  (RESET_N),
      .on     (on_req),
      .target (s_r.level_code),
      .up_step(up_step),
      .dn_step(dn_step),
      .level  (ramp_level)
   );

   assign RDATA               = s_r.rdata;
   assign SINK_B_LEVEL        = ramp_level;
   assign SINK_B_OUTPUT       = on_req || ramp_level != '0;
   assign SINK_B_FLASH_ACTIVE = s_r.state == CSFC_FLASH;

   // Checks
   a_led_gate : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_IDLE && s_r.master_enable && !s_r.function_select && s_r.drive_bit
      && s_r.on_ramp == 2'b00 && !wr_level && !wr_flash |=> SINK_B_OUTPUT && SINK_B_LEVEL == s_r.level_code)
      else $error("LED mode drive bit did not light the sink");

   // A write that sets the enable may light the sink in the next cycle
   a_master_gate : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      !s_r.master_enable && !wr_level |=> !SINK_B_FLASH_ACTIVE && !on_req)
      else $error("sink active while master enable is low");

   a_level_read : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      RD && ADDR == CSFC_ADDR_LEVEL |=> RDATA[CSFC_CODE_LSB +: CSFC_CODE_W] == $past(s_r.level_code)
      && RDATA[CSFC_ENA_BIT] == $past(s_r.master_enable))
      else $error("level register read back wrong");

   a_mode_read : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      RD && ADDR == CSFC_ADDR_FLASH |=> RDATA[CSFC_FMODE_BIT] == $past(s_r.function_select)
      && RDATA[CSFC_TSRC_BIT] == $past(s_r.trigger_source))
      else $error("flash control mode bits read back wrong");

   a_dur_read : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      RD && ADDR == CSFC_ADDR_FLASH |=> RDATA[CSFC_DUR_LSB +: 2] == $past(s_r.pulse_length))
      else $error("pulse length read back wrong");

   a_ramp_read : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      RD && ADDR == CSFC_ADDR_FLASH |=> RDATA[CSFC_ONR_LSB +: 2] == $past(s_r.on_ramp)
      && RDATA[CSFC_OFFR_LSB +: 2] == $past(s_r.off_ramp))
      else $error("ramp selections read back wrong");

   a_led_no_flash : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      !s_r.function_select |=> !SINK_B_FLASH_ACTIVE)
      else $error("flash running in LED mode");

   a_pin_synced : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      pin_rise |-> $past(FLASH_TRIGGER, 2))
      else $error("trigger edge not taken through the synchroniser");

   a_pin_drive_keep : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.trigger_source && !wr_flash |=> $stable(s_r.drive_bit))
      else $error("drive bit changed by a flash with pin source");

   a_repeat_off : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_WAIT && !s_r.repeat_select |=> s_r.state == CSFC_IDLE)
      else $error("repeat wait kept running after repeat was cleared");

   a_reg_trig : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_IDLE && s_r.master_enable && s_r.function_select && !s_r.trigger_source
      && drive_rise |=> SINK_B_FLASH_ACTIVE && s_r.timer == '0)
      else $error("drive bit edge did not start a flash");

   a_pin_trig : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_IDLE && s_r.master_enable && s_r.function_select && s_r.trigger_source
      && pin_rise |=> SINK_B_FLASH_ACTIVE)
      else $error("trigger pin edge did not start a flash");

   a_drive_ignored : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_IDLE && s_r.trigger_source && !pin_rise |=> s_r.state == CSFC_IDLE)
      else $error("flash started without a pin edge");

   a_auto_clear : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_FLASH && s_r.timer >= dur_last && !s_r.trigger_source && !wr_flash
      && s_r.master_enable && s_r.function_select |=> !s_r.drive_bit)
      else $error("drive bit not cleared at flash end");

   a_flash_len : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      $fell(SINK_B_FLASH_ACTIVE) && $past(s_r.master_enable && s_r.function_select) && !$past(wr_flash)
      |-> $past(s_r.timer) == $past(dur_last))
      else $error("flash length differs from the pulse length code");

   a_busy_ignore : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_FLASH && s_r.timer < dur_last && s_r.master_enable && s_r.function_select
      |=> s_r.state == CSFC_FLASH && s_r.timer == $past(s_r.timer) + 1'b1)
      else $error("flash restarted or stopped early");

   a_repeat_wait : assert property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_WAIT && s_r.timer >= CSFC_TW'(REPEAT_CYC - 1) && s_r.repeat_select
      && s_r.master_enable && s_r.function_select |=> SINK_B_FLASH_ACTIVE && s_r.timer == '0)
      else $error("repeat flash not retriggered");

   a_reset_zero : assert property (@(posedge CLOCK)
      !RESET_N |=> !s_r.master_enable && s_r.level_code == '0 && !s_r.function_select
      && !s_r.drive_bit && s_r.pulse_length == '0 && s_r.on_ramp == '0 && s_r.off_ramp == '0)
      else $error("fields not zero after reset");

   c_led_on : cover property (@(posedge CLOCK) disable iff (!RESET_N)
      !s_r.function_select && on_req);
   c_reg_flash : cover property (@(posedge CLOCK) disable iff (!RESET_N)
      $fell(SINK_B_FLASH_ACTIVE) && !s_r.trigger_source);
   c_pin_flash : cover property (@(posedge CLOCK) disable iff (!RESET_N)
      $rose(SINK_B_FLASH_ACTIVE) && s_r.trigger_source);
   c_repeat : cover property (@(posedge CLOCK) disable iff (!RESET_N)
      s_r.state == CSFC_WAIT ##1 SINK_B_FLASH_ACTIVE);
   c_ramp_up : cover property (@(posedge CLOCK) disable iff (!RESET_N)
      on_req && ramp_level != '0 && ramp_level < s_r.level_code);
endmodule

// File: sim/csfc_led_model.sv
// Flash LED model that times each light pulse of sink B
module csfc_led_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Sink drive
   input  wire logic        active,
   // Pulse record
   output logic             done,
   output logic      [15:0] width,
   output logic      [15:0] gap,
   output logic      [15:0] pulses
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        act_d;
   logic [15:0] cnt;
   logic [15:0] since;
   // Counts lit cycles of each pulse and the spacing of pulse starts
   always @(posedge clk) begin
      done <= 1'b0;
      if (!rst_n) begin
         act_d  <= 1'b0;
         cnt    <= 16'h0000;
         since  <= 16'h0000;
         width  <= 16'h0000;
         gap    <= 16'h0000;
         pulses <= 16'h0000;
      end else begin
         since <= since + 16'h0001;
         act_d <= active;
         if (active) begin
            cnt <= cnt + 16'h0001;
         end
         if (active && !act_d) begin
            gap    <= since;
            since  <= 16'h0001;
            cnt    <= 16'h0001;
            pulses <= pulses + 16'h0001;
         end
         if (!active && act_d) begin
            width <= cnt;
            done  <= 1'b1;
         end
      end
   end
endmodule

// File: sim/tb.sv
// Self-checking bench for the sink B flash control block
module tb import csfc_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DC[3] = '{8, 16, 24};
   logic                   CLOCK = 1'b0;
   logic                   RESET_N = 1'b0;
   logic [7:0]             ADDR = 8'h00;
   logic [15:0]            WDATA = 16'h0000;
   logic                   WR = 1'b0;
   logic                   RD = 1'b0;
   logic                   FLASH_TRIGGER = 1'b0;
   logic [15:0]            RDATA;
   logic                   SINK_B_OUTPUT;
   logic [CSFC_CODE_W-1:0] SINK_B_LEVEL;
   logic                   SINK_B_FLASH_ACTIVE;
   logic                   done;
   logic [15:0]            width;
   logic [15:0]            gap;
   logic [15:0]            pulses;
   logic [15:0]            p0;
   logic                   rd_d = 1'b0;
   logic [15:0]            exp_rd[$];
   logic [15:0]            exp_w[$];
   logic [5:0]             code;
   int                     n_errors = 0;
   int                     cmp_count = 0;
   int                     seed = 89309;
   always #25 CLOCK = ~CLOCK;
   csfc_top #(.DUR0_CYC(DC[0]), .DUR1_CYC(DC[1]), .DUR2_CYC(DC[2]), .REPEAT_CYC(100),
      .LRAMP1_CYC(128)) i_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .FLASH_TRIGGER(FLASH_TRIGGER), .SINK_B_OUTPUT(SINK_B_OUTPUT),
      .SINK_B_LEVEL(SINK_B_LEVEL), .SINK_B_FLASH_ACTIVE(SINK_B_FLASH_ACTIVE));
   csfc_led_model i_led (.clk(CLOCK), .rst_n(RESET_N), .active(SINK_B_FLASH_ACTIVE), .done(done),
      .width(width), .gap(gap), .pulses(pulses));
   task automatic check(string name, logic [15:0] seen, logic [15:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", name, expv, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge CLOCK);
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge CLOCK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLOCK);
      WR    <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [15:0] e);
      @(posedge CLOCK);
      ADDR <= a;
      RD   <= 1'b1;
      exp_rd.push_back(e);
      @(posedge CLOCK);
      RD   <= 1'b0;
   endtask
   task automatic wait_act(logic v, int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         @(posedge CLOCK);
         if (SINK_B_FLASH_ACTIVE === v) break;
      end
      if (i == bound) begin
         $display("BAD flash_active exp %b seen %b", v, SINK_B_FLASH_ACTIVE);
         n_errors++;
         tally_and_finish();
      end
   endtask
   // Monitor: read data one cycle after the strobe, pulse lengths as the LED reports them
   always @(posedge CLOCK) begin
      rd_d <= RD;
      if (rd_d) check("rdata", RDATA, exp_rd.pop_front());
      if (done) check("flash_len", width, exp_w.size() > 0 ? exp_w.pop_front() : 16'hffff);
   end
   initial begin
      idle(20000);
      $display("BAD watchdog exp finish seen hang");
      n_errors++;
      tally_and_finish();
   end
   initial begin
      idle(8);
      RESET_N <= 1'b1;
      rd(CSFC_ADDR_LEVEL, CSFC_LEVEL_RST);
      rd(CSFC_ADDR_FLASH, CSFC_FLASH_RST);
      wr(8'h10, 16'hffff);
      rd(8'h10, 16'h0000);
      code = 6'($random(seed)) | 6'h01;
      wr(CSFC_ADDR_LEVEL, {10'h200, code});
      rd(CSFC_ADDR_LEVEL, {10'h200, code});
      $display("test registers done");
      wr(CSFC_ADDR_FLASH, 16'h6000);
      idle(3);
      check("led_on", {15'h0000, SINK_B_OUTPUT}, 16'h0001);
      check("led_level", {10'h000, SINK_B_LEVEL}, {10'h000, code});
      check("led_no_flash", {15'h0000, SINK_B_FLASH_ACTIVE}, 16'h0000);
      wr(CSFC_ADDR_FLASH, 16'h4000);
      idle(3);
      check("led_off", {15'h0000, SINK_B_OUTPUT}, 16'h0000);
      check("off_level", {10'h000, SINK_B_LEVEL}, 16'h0000);
      wr(CSFC_ADDR_LEVEL, {10'h000, code});
      wr(CSFC_ADDR_FLASH, 16'h2000);
      idle(3);
      check("disabled", {15'h0000, SINK_B_OUTPUT}, 16'h0000);
      $display("test led mode done");
      wr(CSFC_ADDR_FLASH, 16'h2001);
      wr(CSFC_ADDR_LEVEL, 16'h8020);
      idle(10);
      check("ramp_up_mid", {15'h0000, (SINK_B_LEVEL < 6'h20) && (SINK_B_LEVEL != 6'h00)}, 16'h0001);
      idle(80);
      check("ramp_up_end", {10'h000, SINK_B_LEVEL}, 16'h0020);
      wr(CSFC_ADDR_FLASH, 16'h0010);
      idle(10);
      check("ramp_dn_mid", {15'h0000, (SINK_B_LEVEL < 6'h20) && (SINK_B_LEVEL != 6'h00)}, 16'h0001);
      idle(80);
      check("ramp_dn_end", {10'h000, SINK_B_LEVEL}, 16'h0000);
      $display("test ramps done");
      for (int d = 0; d < 3; d++) begin
         exp_w.push_back(16'(DC[d]));
         wr(CSFC_ADDR_FLASH, 16'ha000 | 16'(d << 8));
         wait_act(1'b1, 6);
         wait_act(1'b0, 60);
         idle(2);
         rd(CSFC_ADDR_FLASH, 16'h8000 | 16'(d << 8));
      end
      // Longest code outlasts the run: cut it, lit 1 seen + 32 waited + 3 for the abort write
      exp_w.push_back(16'h0024);
      wr(CSFC_ADDR_FLASH, 16'ha300);
      wait_act(1'b1, 6);
      idle(32);
      check("long_flash", {15'h0000, SINK_B_FLASH_ACTIVE}, 16'h0001);
      wr(CSFC_ADDR_FLASH, 16'h0300);
      wait_act(1'b0, 4);
      idle(2);
      rd(CSFC_ADDR_FLASH, 16'h0300);
      $display("test register flash done");
      wr(CSFC_ADDR_FLASH, 16'he000);
      idle(20);
      check("drive_no_flash", {15'h0000, SINK_B_FLASH_ACTIVE}, 16'h0000);
      rd(CSFC_ADDR_FLASH, 16'he000);
      p0 = pulses;
      exp_w.push_back(16'h0008);
      FLASH_TRIGGER <= 1'b1;
      wait_act(1'b1, 6);
      FLASH_TRIGGER <= 1'b0;
      idle(1);
      FLASH_TRIGGER <= 1'b1;
      wait_act(1'b0, 20);
      FLASH_TRIGGER <= 1'b0;
      idle(10);
      check("pin_flashes", pulses - p0, 16'h0001);
      $display("test pin flash done");
      wr(CSFC_ADDR_FLASH, 16'hd000);
      exp_w.push_back(16'h0008);
      exp_w.push_back(16'h0008);
      FLASH_TRIGGER <= 1'b1;
      wait_act(1'b1, 6);
      FLASH_TRIGGER <= 1'b0;
      wait_act(1'b0, 20);
      wait_act(1'b1, 110);
      idle(1);
      check("repeat_gap", gap, 16'h0064);
      wait_act(1'b0, 20);
      wr(CSFC_ADDR_FLASH, 16'h0000);
      p0 = pulses;
      idle(120);
      check("repeat_stop", pulses - p0, 16'h0000);
      $display("test repeat done");
      wr(CSFC_ADDR_LEVEL, 16'h803f);
      RESET_N <= 1'b0;
      idle(2);
      RESET_N <= 1'b1;
      rd(CSFC_ADDR_LEVEL, 16'h0000);
      rd(CSFC_ADDR_FLASH, 16'h0000);
      idle(3);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
